// ---- rtl/eeprom_front_pkg.sv ----
// Package for the two-wire EEPROM serial front end.
// Assumes a single system clock plus the bus clock pin as a second domain.
package eeprom_front_pkg;

  // ****************************************
  // Select byte layout
  // ****************************************
  // Device type code; value is arbitrary
  localparam logic [3:0] DEV_TYPE_ID = 4'hB;
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_CE_MSB = 3;
  localparam int SEL_CE_LSB = 1;
  localparam int SEL_RW_BIT = 0;
  localparam logic SEL_RW_READ = 1'b1;

  // ****************************************
  // Address layout and counts
  // ****************************************
  localparam int ADDR_HI_MSB = 15;
  localparam int ADDR_HI_LSB = 8;
  localparam int ADDR_LO_MSB = 7;
  localparam int ADDR_LO_LSB = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] STOP_SLOT_MAX = 4'h1;
  localparam int SYNC_WIDTH = 8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;

  // ****************************************
  // Serial states
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SELECT = 3'h1,
    ST_ADDR_HI = 3'h2,
    ST_ADDR_LO = 3'h3,
    ST_DATA_WR = 3'h4,
    ST_DATA_RD = 3'h5,
    ST_BUSY = 3'h6
  } state_t;

endpackage : eeprom_front_pkg

// ---- rtl/eeprom_serial_front.sv ----
// Serial front end of a two-wire slave EEPROM: Start/Stop, select, address, ack.
// Assumes the memory core sits on sys_clk_i and supplies read bytes and write done.
// Function
// - Write protect high blocks all writes
// - Floating write protect reads low, writes allowed
// - Protected: ack select and address, nack data
// - Ignore bus until supply passes threshold
// - Below threshold stop answering the bus
// - Start is SDA fall with SCL high
// - Nothing answered without preceding Start
// - Watch for Start except during write
// - Stop is SDA rise with SCL high
// - Stop ends transfer, interface idles
// - Stop after read nack gives standby
// - Stop ending write starts write cycle
// - Transmitter releases SDA after eight bits
// - Receiver pulls SDA low on ninth pulse
// - Select byte: type, chip enable, direction
// - Select byte shifted most significant first
// - Chip enable bits compared with straps
// - Address high byte first, then low
// - Device is slave; master clocks bus
// - Sample SDA on SCL rising edge
// - Match acks ninth slot; mismatch goes standby
// - Direction bit one reads, zero writes
`timescale 1ns/100ps
module eeprom_serial_front
  import eeprom_front_pkg::*;
(
  // Clocks and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_clk_i,
  // Serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Straps and supply
  input wire logic write_protect_in_i,
  input wire logic strap_select_0_i,
  input wire logic strap_select_1_i,
  input wire logic strap_select_2_i,
  input wire logic por_ok_i,
  // Memory core side
  output logic [15:0] mem_addr_o,
  output logic addr_load_o,
  output logic [7:0] wr_data_o,
  output logic wr_strobe_o,
  output logic wr_start_o,
  input wire logic wr_done_i,
  input wire logic [7:0] rd_data_i,
  output logic rd_take_o
);

  // ****************************************
  // Link domain: bit capture on SCL
  // ****************************************
  typedef struct packed {
    logic bit_v;
    logic tog;
  } link_state_t;

  link_state_t lk_q;
  link_state_t lk_d;

  always_comb begin
    lk_d.bit_v = sda_i;
    lk_d.tog = ~lk_q.tog;
  end

  // Link register, only ticks while master clocks
  always_ff @(posedge scl_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // ****************************************
  // Crossing of pins and toggle
  // ****************************************
  logic [SYNC_WIDTH-1:0] sync_q;
  logic por_s;
  logic wp_s;
  logic [2:0] strap_s;
  logic sda_s;
  logic scl_s;
  logic tog_s;

  level_sync #(
    .W(SYNC_WIDTH)
  ) u_sync (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .d_i({por_ok_i, write_protect_in_i, strap_select_2_i, strap_select_1_i,
          strap_select_0_i, sda_i, scl_clk_i, lk_q.tog}),
    .q_o(sync_q)
  );

  // Synchronised views
  assign por_s = sync_q[7];
  assign wp_s = sync_q[6];
  assign strap_s = sync_q[5:3];
  assign sda_s = sync_q[2];
  assign scl_s = sync_q[1];
  assign tog_s = sync_q[0];

  // ****************************************
  // System domain state
  // ****************************************
  typedef struct packed {
    state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [15:0] addr;
    logic [7:0] wr_data;
    logic ack_phase;
    logic ack_ours;
    logic drive_low;
    logic wr_armed;
    logic tog_seen;
    logic scl_prev;
    logic sda_prev;
    logic addr_load;
    logic wr_strobe;
    logic wr_start;
    logic rd_take;
  } front_state_t;

  front_state_t s_q;
  front_state_t s_d;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  logic byte_in;
  logic sel_match;

  // start and stop seen with SCL high
  assign start_ev = scl_s & s_q.scl_prev & s_q.sda_prev & ~sda_s;
  assign stop_ev = scl_s & s_q.scl_prev & ~s_q.sda_prev & sda_s;
  assign rise_ev = tog_s ^ s_q.tog_seen;
  assign fall_ev = s_q.scl_prev & ~scl_s;
  assign byte_in = (s_q.bit_cnt == BITS_PER_BYTE) & ~s_q.ack_phase;
  assign sel_match = (s_q.shift[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE_ID) &&
                     (s_q.shift[SEL_CE_MSB:SEL_CE_LSB] == strap_s);

  // Next state of the serial engine
  always_comb begin
    s_d = s_q;
    s_d.tog_seen = tog_s;
    s_d.scl_prev = scl_s;
    s_d.sda_prev = sda_s;
    s_d.addr_load = 1'b0;
    s_d.wr_strobe = 1'b0;
    s_d.wr_start = 1'b0;
    s_d.rd_take = 1'b0;
    if (!por_s) begin
      s_d.st = ST_IDLE;
      s_d.drive_low = 1'b0;
      s_d.ack_phase = 1'b0;
      s_d.wr_armed = 1'b0;
    end else if (s_q.st == ST_BUSY) begin
      if (wr_done_i) begin
        s_d.st = ST_IDLE;
      end
    end else if (start_ev) begin
      s_d.st = ST_SELECT;
      s_d.bit_cnt = CNT_RST;
      s_d.ack_phase = 1'b0;
      s_d.drive_low = 1'b0;
      s_d.wr_armed = 1'b0;
    end else if (stop_ev) begin
      s_d.drive_low = 1'b0;
      s_d.ack_phase = 1'b0;
      s_d.st = ST_IDLE;
      // Stop in slot after data ack
      if (s_q.st == ST_DATA_WR && s_q.wr_armed && !s_q.ack_phase &&
          s_q.bit_cnt <= STOP_SLOT_MAX) begin
        s_d.st = ST_BUSY;
        s_d.wr_start = 1'b1;
      end
      s_d.wr_armed = 1'b0;
    end else begin
      case (s_q.st)
        ST_IDLE: begin
          s_d.drive_low = 1'b0;
        end
        ST_SELECT, ST_ADDR_HI, ST_ADDR_LO, ST_DATA_WR: begin
          if (rise_ev && !s_q.ack_phase) begin
            s_d.shift = {s_q.shift[6:0], lk_q.bit_v};
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end else if (fall_ev && byte_in) begin
            s_d.bit_cnt = CNT_RST;
            s_d.ack_phase = 1'b1;
            s_d.ack_ours = 1'b1;
            // ack pulled low for ninth pulse
            s_d.drive_low = 1'b1;
            case (s_q.st)
              ST_SELECT: begin
                if (sel_match) begin
                  s_d.st = (s_q.shift[SEL_RW_BIT] == SEL_RW_READ) ? ST_DATA_RD : ST_ADDR_HI;
                end else begin
                  s_d.st = ST_IDLE;
                  s_d.drive_low = 1'b0;
                  s_d.ack_phase = 1'b0;
                end
              end
              ST_ADDR_HI: begin
                s_d.addr[ADDR_HI_MSB:ADDR_HI_LSB] = s_q.shift;
                s_d.st = ST_ADDR_LO;
              end
              ST_ADDR_LO: begin
                s_d.addr[ADDR_LO_MSB:ADDR_LO_LSB] = s_q.shift;
                s_d.addr_load = 1'b1;
                s_d.st = ST_DATA_WR;
              end
              default: begin
                if (wp_s) begin
                  s_d.drive_low = 1'b0;
                end else begin
                  s_d.wr_data = s_q.shift;
                  s_d.wr_strobe = 1'b1;
                  s_d.wr_armed = 1'b1;
                end
              end
            endcase
          end else if (fall_ev && s_q.ack_phase) begin
            s_d.ack_phase = 1'b0;
            s_d.drive_low = 1'b0;
          end
        end
        ST_DATA_RD: begin
          if (rise_ev && s_q.ack_phase && !s_q.ack_ours && lk_q.bit_v) begin
            s_d.st = ST_IDLE;
            s_d.ack_phase = 1'b0;
          end else if (rise_ev && !s_q.ack_phase) begin
            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
          end else if (fall_ev && s_q.ack_phase) begin
            // Load next read byte, drive its MSB
            s_d.ack_phase = 1'b0;
            s_d.shift = rd_data_i;
            s_d.rd_take = 1'b1;
            s_d.bit_cnt = CNT_RST;
            s_d.drive_low = ~rd_data_i[7];
          end else if (fall_ev && s_q.bit_cnt == BITS_PER_BYTE) begin
            s_d.drive_low = 1'b0;
            s_d.ack_phase = 1'b1;
            s_d.ack_ours = 1'b0;
          end else if (fall_ev) begin
            s_d.shift = {s_q.shift[6:0], 1'b0};
            s_d.drive_low = ~s_q.shift[6];
          end
        end
        default: begin
          s_d.st = ST_IDLE;
          s_d.drive_low = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q.st <= ST_IDLE;
      s_q.bit_cnt <= CNT_RST;
      s_q.shift <= BYTE_RST;
      s_q.addr <= ADDR_RST;
      s_q.wr_data <= BYTE_RST;
      s_q.ack_phase <= 1'b0;
      s_q.ack_ours <= 1'b0;
      s_q.drive_low <= 1'b0;
      s_q.wr_armed <= 1'b0;
      s_q.tog_seen <= 1'b0;
      s_q.scl_prev <= 1'b0;
      s_q.sda_prev <= 1'b0;
      s_q.addr_load <= 1'b0;
      s_q.wr_strobe <= 1'b0;
      s_q.wr_start <= 1'b0;
      s_q.rd_take <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // open-drain: only ever drives low
  assign sda_o = 1'b0;
  assign sda_oe_o = s_q.drive_low;
  assign mem_addr_o = s_q.addr;
  assign addr_load_o = s_q.addr_load;
  assign wr_data_o = s_q.wr_data;
  assign wr_strobe_o = s_q.wr_strobe;
  assign wr_start_o = s_q.wr_start;
  assign rd_take_o = s_q.rd_take;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_drive_when_allowed: assert property (
    sda_oe_o |-> (s_q.ack_phase || s_q.st == ST_DATA_RD)
  ) else $error("SDA driven outside ack or read");

  chk_wp_no_strobe: assert property (
    wr_strobe_o |-> !$past(wp_s)
  ) else $error("Write strobe while protected");

  chk_wp_data_nack: assert property (
    (por_s && s_q.st == ST_DATA_WR && fall_ev && byte_in && wp_s && !start_ev && !stop_ev)
      |=> (!sda_oe_o && s_q.ack_phase)
  ) else $error("Protected data byte was acked");

  chk_por_quiet: assert property (
    !por_s |=> (s_q.st == ST_IDLE && !sda_oe_o && !wr_start_o)
  ) else $error("Active below supply threshold");

  chk_start_select: assert property (
    (por_s && start_ev && s_q.st != ST_BUSY) |=> (s_q.st == ST_SELECT && s_q.bit_cnt == CNT_RST)
  ) else $error("Start not taken");

  chk_busy_deaf: assert property (
    (por_s && s_q.st == ST_BUSY && !wr_done_i) |=> (s_q.st == ST_BUSY && !sda_oe_o)
  ) else $error("Left write cycle early");

  chk_stop_idle: assert property (
    (por_s && stop_ev && s_q.st != ST_BUSY && s_q.st != ST_DATA_WR) |=> (s_q.st == ST_IDLE && !sda_oe_o)
  ) else $error("Stop did not idle");

  chk_wstart_cause: assert property (
    wr_start_o |-> (s_q.st == ST_BUSY && $past(s_q.st) == ST_DATA_WR && $past(s_q.wr_armed))
  ) else $error("Write start without write stop");

  chk_mismatch_idle: assert property (
    (por_s && s_q.st == ST_SELECT && fall_ev && byte_in && !sel_match && !start_ev && !stop_ev)
      |=> (s_q.st == ST_IDLE && !sda_oe_o) [*2]
  ) else $error("Mismatched select not released");

endmodule : eeprom_serial_front

// ---- rtl/level_sync.sv ----
// Two flip-flop level synchroniser for a vector of unrelated inputs.
// Assumes each bit is a slow level or a toggle; no bus coherence implied.
`timescale 1ns/100ps
module level_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // Next state: first stage feeds only the second
  always_comb begin
    s_d.meta = d_i;
    s_d.stable = s_q.meta;
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_o = s_q.stable;

endmodule : level_sync

// ---- testbench/i2c_master_model.sv ----
// Two-wire bus master model: clocks SCL and pulls SDA low.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/100ps
module i2c_master_model (
  // Bus lines
  output logic scl_o,
  output logic pull_o,
  input wire logic sda_i
);
  // ****************************************
  // Bus primitives
  // ****************************************
  // Idle bus: clock stands high, data released
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // one pulse, data changed while low
  task automatic bit_io(input logic b, output logic s);
    pull_o = ~b;
    #31.3 scl_o = 1'b1;
    #31.2 s = sda_i;
    #31.3 scl_o = 1'b0;
    #31.2;
  endtask : bit_io
  task automatic start();
    pull_o = 1'b0;
    #31.3 pull_o = 1'b1;
    #31.2 scl_o = 1'b0;
    #31.3;
  endtask : start
  task automatic stop();
    pull_o = 1'b1;
    #31.3 scl_o = 1'b1;
    #31.2 pull_o = 1'b0;
    #62.5;
  endtask : stop
  // MSB first, released for the ack
  task automatic send_byte(input logic [7:0] d, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, nack);
  endtask : send_byte
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, s);
  endtask : recv_byte
endmodule : i2c_master_model

// ---- testbench/tb_eeprom_serial_front.sv ----
// Self-checking bench of the serial front end with a bus master model.
// Assumes the master model and the design package are compiled first.
`timescale 1ns/100ps
module tb_eeprom_serial_front;
  import eeprom_front_pkg::*;
  typedef struct packed {logic [1:0] k; logic [15:0] v;} note_t;
  logic sys_clk_i, rst_b_i, scl, pull, sda, sda_o, sda_oe_o, wp, por, wr_done, addr_load, wr_strobe, wr_start, rd_take;
  logic [2:0] ce;
  logic [7:0] rd_data, wr_data, got;
  logic [7:0] rd_q[$];
  logic [15:0] mem_addr;
  logic [31:0] rnd;
  int error_cnt, n_checks, cycles;
  note_t notes[$];
  // ****************************************
  // Clock, bus wire and instances
  // ****************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  assign sda = ~(sda_oe_o | pull);
  i2c_master_model m (.scl_o(scl), .pull_o(pull), .sda_i(sda));
  eeprom_serial_front dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .scl_clk_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .write_protect_in_i(wp), .strap_select_0_i(ce[0]), .strap_select_1_i(ce[1]),
    .strap_select_2_i(ce[2]), .por_ok_i(por), .mem_addr_o(mem_addr), .addr_load_o(addr_load), .wr_data_o(wr_data),
    .wr_strobe_o(wr_strobe), .wr_start_o(wr_start), .wr_done_i(wr_done), .rd_data_i(rd_data), .rd_take_o(rd_take));
  // ****************************************
  // Checking
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Bus answers and read bytes
  task automatic cmp_bus(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected bus value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_bus
  // Core pulses against the oldest note
  task automatic cmp_core(input note_t g);
    note_t e;
    e = 'x;
    if (notes.size() > 0) e = notes.pop_front();
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected core pulse at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_core
  // Watch core strobes mid-cycle
  always @(negedge sys_clk_i) begin
    if (addr_load === 1'b1) cmp_core({2'h0, mem_addr});
    if (wr_strobe === 1'b1) cmp_core({2'h1, 8'h00, wr_data});
    if (wr_start === 1'b1) cmp_core({2'h2, 16'h0000});
    if (rd_take === 1'b1) cmp_core({2'h3, 8'h00, rd_data});
  end
  // Core model: present oldest queued read byte, advance on each take
  always @(negedge sys_clk_i) begin
    if (rd_take === 1'b1 && rd_q.size() > 0) rd_q.delete(0);
    rd_data <= (rd_q.size() > 0) ? rd_q[0] : 8'h00;
  end
  task automatic tally_and_finish();
    if (notes.size() > 0) error_cnt++;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Hang guard
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic tx(input logic [7:0] b, input logic nack);
    logic a;
    m.send_byte(b, a);
    cmp_bus({7'h00, a}, {7'h00, nack});
  endtask : tx
  task automatic new_straps();
    rnd = lfsr(rnd);
    @(negedge sys_clk_i);
    ce = rnd[26:24];
    repeat (5) @(negedge sys_clk_i);
  endtask : new_straps
  task automatic wr_test(input logic p);
    logic [15:0] a;
    logic [7:0] d;
    new_straps();
    a = rnd[15:0];
    d = rnd[23:16];
    wp = p;
    repeat (5) @(negedge sys_clk_i);
    notes.push_back({2'h0, a});
    if (!p) notes.push_back({2'h1, 8'h00, d});
    if (!p) notes.push_back({2'h2, 16'h0000});
    m.start();
    tx({DEV_TYPE_ID, ce, 1'b0}, 1'b0);
    tx(a[15:8], 1'b0);
    tx(a[7:0], 1'b0);
    tx(d, p);
    m.stop();
    repeat (10) @(negedge sys_clk_i);
    if (!p) begin
      // busy write cycle ignores the bus
      m.start();
      tx({DEV_TYPE_ID, ce, 1'b0}, 1'b1);
      m.stop();
      @(negedge sys_clk_i);
      wr_done = 1'b1;
      @(negedge sys_clk_i);
      wr_done = 1'b0;
    end
    repeat (10) @(negedge sys_clk_i);
    $display("test write protect=%0d done", p);
  endtask : wr_test
  initial begin
    rst_b_i = 1'b0;
    wp = 1'b0;
    por = 1'b0;
    wr_done = 1'b0;
    ce = 3'h0;
    rnd = 32'hF68B68CE;
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_b_i = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    m.start();
    tx({DEV_TYPE_ID, ce, 1'b0}, 1'b1);
    m.stop();
    @(negedge sys_clk_i);
    por = 1'b1;
    repeat (10) @(negedge sys_clk_i);
    $display("test supply done");
    wr_test(1'b0);
    wr_test(1'b1);
    // wrong chip enable gets no ack
    new_straps();
    m.start();
    tx({DEV_TYPE_ID, ce ^ 3'h5, 1'b0}, 1'b1);
    m.stop();
    $display("test select mismatch done");
    // two read bytes: master ack, then nack and stop
    new_straps();
    rd_q.push_back(rnd[7:0]);
    rd_q.push_back(rnd[15:8]);
    notes.push_back({2'h3, 8'h00, rnd[7:0]});
    notes.push_back({2'h3, 8'h00, rnd[15:8]});
    m.start();
    tx({DEV_TYPE_ID, ce, SEL_RW_READ}, 1'b0);
    m.recv_byte(1'b1, got);
    cmp_bus(got, rnd[7:0]);
    m.recv_byte(1'b0, got);
    cmp_bus(got, rnd[15:8]);
    m.stop();
    repeat (10) @(negedge sys_clk_i);
    cmp_bus({7'h00, sda_oe_o}, 8'h00);
    cmp_bus({7'h00, sda_o}, 8'h00);
    $display("test read done");
    tally_and_finish();
  end
endmodule : tb_eeprom_serial_front
